//--- hdl/dma_channel_control.sv
// one dma channel: control registers, item sequencing, bus master, irq
//
// Overview of operation
// - without wrap mode the channel stops after the length and clears run.
// - wrap with peripheral trigger keeps run, zeroes index, restarts.
// - source address fixed, or advances 1, 2 or 4 per item by width.
// - destination address fixed, or advances 1, 2 or 4 per item by width.
// - trigger select 0 starts at once; 1 waits for peripheral requests.
// - the channel interrupt is raised only while the interrupt gate is set.
// - width code 00, 01, 10 selects 1, 2, 4 bytes; 11 reserved.
// - run bit 0 keeps the channel idle; setting it enables the channel.
// - read-only index counts items and returns to zero at completion.
// - each address is start plus index scaled by width when incrementing.
// - each start address is two writable 16-bit halves.
// - last channel in secure boot forces destination to key store base.
// - irq when match count equals index before increment, gate set.
// - the channel moves one item more than the programmed length.
// - request sense 0 is level, 1 is rising edge.
// - higher priority value wins; on a tie lower channel number wins.
`timescale 1ns/1ns
`include "dma_chan_defines.svh"
module dma_channel_control #(
  parameter int unsigned NCH            = 8,
  parameter int unsigned CHAN           = 7,
  parameter bit          IS_LAST        = 1'b1,
  parameter logic [31:0] KEY_STORE_BASE = 32'h0000_0000
) (
  // clock and reset
  input  wire logic             mclk,
  input  wire logic             rst,
  // avalon-mm slave
  input  wire logic [31:0]      avs_address,
  input  wire logic             avs_read,
  input  wire logic             avs_write,
  input  wire logic [3:0]       avs_byteenable,
  input  wire logic [31:0]      avs_writedata,
  output logic      [31:0]      avs_readdata,
  output logic                  avs_waitrequest,
  // pins
  input  wire logic             dreq,
  input  wire logic             secure_boot,
  // other channels competing for the bus
  input  wire logic [NCH-1:0]   peer_req,
  input  wire logic [3*NCH-1:0] peer_prio,
  // system bus master
  output logic                  bus_req,
  output logic                  bus_we,
  output logic      [31:0]      bus_addr,
  output logic      [31:0]      bus_wdata,
  output logic      [1:0]       bus_size,
  input  wire logic             bus_ack,
  input  wire logic [31:0]      bus_rdata,
  // status
  output logic                  chan_req,
  output logic                  irq
);

  //////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic [1:0] width_eff(input logic [1:0] w);
    // reserved code behaves as single byte
    return (w == dma_chan_pkg::W_RSVD) ? 2'(dma_chan_pkg::W_BYTE) : w;
  endfunction

  function automatic logic [31:0] calc_addr(input logic [31:0] start,
                                            input logic [15:0] idx,
                                            input logic        incr,
                                            input logic [1:0]  w);
    logic [31:0] step;
    step = {16'h0000, idx} << width_eff(w);
    return incr ? start + step : start;
  endfunction

  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0]  be);
    return {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // state and registers

  dma_chan_pkg::chan_state_t state_r;
  logic [15:0]               ctrl_r;
  logic [15:0]               idx_r;
  logic [15:0]               src_lo_r;
  logic [15:0]               src_hi_r;
  logic [15:0]               dst_lo_r;
  logic [15:0]               dst_hi_r;
  logic [15:0]               match_r;
  logic [15:0]               len_r;
  logic [`STAT_BITS-1:0]     status_r;
  logic [`STAT_BITS-1:0]     mask_r;
  logic                      wait_r;
  logic                      sec1_r;
  logic                      sec2_r;
  logic [31:0]               rd_val;
  logic                      wr_en;
  logic                      rd_en;
  logic                      req_ok;
  logic [NCH-1:0]            req_vec;
  logic [3*NCH-1:0]          prio_vec;
  logic [NCH-1:0]            grant;
  logic                      item_done;
  logic                      last_item;
  logic                      ctrl_wr;
  logic                      restart;
  logic                      sec_force;
  logic [31:0]               src_start;
  logic [31:0]               dst_start;
  logic [`STAT_BITS-1:0]     events;

  wire run     = ctrl_r[`CTRL_RUN];
  wire trig    = ctrl_r[`CTRL_TRIG];
  wire irq_en  = ctrl_r[`CTRL_IRQ_EN];
  wire [1:0] w = ctrl_r[`CTRL_WIDTH_HI:`CTRL_WIDTH_LO];

  assign wr_en     = avs_write && !wait_r;
  assign rd_en     = avs_read && !wait_r;
  assign ctrl_wr   = wr_en && avs_address == `OFS_CTRL;
  assign item_done = state_r == dma_chan_pkg::ST_WR && bus_ack;
  assign last_item = idx_r == len_r;
  assign restart   = ctrl_r[`CTRL_WRAP] && trig;
  assign sec_force = IS_LAST && sec2_r;
  assign src_start = {src_hi_r, src_lo_r};
  assign dst_start = sec_force ? KEY_STORE_BASE
                               : {dst_hi_r, dst_lo_r};

  //////////////////////////////////////////////////////////////////////////
  // avalon slave: one wait cycle, then the access is taken

  always_ff @(posedge mclk) begin
    if (rst) begin
      wait_r <= 1'b1;
    end else if ((avs_read || avs_write) && wait_r) begin
      wait_r <= 1'b0;
    end else begin
      wait_r <= 1'b1;
    end
  end

  always_comb begin
    rd_val = 32'h0000_0000;
    case (avs_address)
      `OFS_CTRL:      rd_val[15:0] = ctrl_r;
      `OFS_IDX:       rd_val[15:0] = idx_r;
      `OFS_SRC_LO:    rd_val[15:0] = src_lo_r;
      `OFS_SRC_HI:    rd_val[15:0] = src_hi_r;
      `OFS_DST_LO:    rd_val[15:0] = dst_start[15:0];
      `OFS_DST_HI:    rd_val[15:0] = dst_start[31:16];
      `OFS_IRQ_MATCH: rd_val[15:0] = match_r;
      `OFS_LEN:       rd_val[15:0] = len_r;
      `OFS_STATUS:    rd_val[`STAT_BITS-1:0] = status_r;
      `OFS_MASK:      rd_val[`STAT_BITS-1:0] = mask_r;
      default:        rd_val = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && wait_r) begin
      avs_readdata <= rd_val;
    end
  end

  assign avs_waitrequest = wait_r;

  always_ff @(posedge mclk) begin
    if (rst) begin
      src_lo_r <= `RST_REG16;
      src_hi_r <= `RST_REG16;
      dst_lo_r <= `RST_REG16;
      dst_hi_r <= `RST_REG16;
      match_r  <= `RST_REG16;
      len_r    <= `RST_REG16;
      mask_r   <= `RST_STAT;
    end else if (wr_en) begin
      case (avs_address)
        `OFS_SRC_LO: src_lo_r <= merge16(src_lo_r, avs_writedata,
                                         avs_byteenable);
        `OFS_SRC_HI: src_hi_r <= merge16(src_hi_r, avs_writedata,
                                         avs_byteenable);
        `OFS_DST_LO: dst_lo_r <= merge16(dst_lo_r, avs_writedata,
                                         avs_byteenable);
        `OFS_DST_HI: dst_hi_r <= merge16(dst_hi_r, avs_writedata,
                                         avs_byteenable);
        `OFS_IRQ_MATCH: match_r <= merge16(match_r, avs_writedata,
                                           avs_byteenable);
        `OFS_LEN: len_r <= merge16(len_r, avs_writedata, avs_byteenable);
        `OFS_MASK: begin
          if (avs_byteenable[0]) begin
            mask_r <= avs_writedata[`STAT_BITS-1:0];
          end
        end
        default: ;
      endcase
    end
  end

  // run bit: software write wins over the self-clear
  always_ff @(posedge mclk) begin
    if (rst) begin
      ctrl_r <= `RST_REG16;
    end else if (ctrl_wr) begin
      ctrl_r <= merge16(ctrl_r, avs_writedata, avs_byteenable) & `CTRL_WMASK;
    end else if (item_done && last_item && !restart) begin
      ctrl_r[`CTRL_RUN] <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // secure boot strap and peripheral request

  always_ff @(posedge mclk) begin
    if (rst) begin
      sec1_r <= 1'b0;
      sec2_r <= 1'b0;
    end else begin
      sec1_r <= secure_boot;
      sec2_r <= sec1_r;
    end
  end

  dma_req_sync u_req (
    .mclk       (mclk),
    .rst        (rst),
    .dreq       (dreq),
    .edge_sense (ctrl_r[`CTRL_SENSE]),
    .consume    (state_r == dma_chan_pkg::ST_WAIT && req_ok),
    .req_ok     (req_ok)
  );

  always_comb begin
    req_vec             = peer_req;
    req_vec[CHAN]       = chan_req;
    prio_vec            = peer_prio;
    prio_vec[3*CHAN +: 3] = ctrl_r[`CTRL_PRIO_HI:`CTRL_PRIO_LO];
  end

  chan_priority_arbiter #(.NCH(NCH)) u_arb (
    .req   (req_vec),
    .prio  (prio_vec),
    .grant (grant)
  );

  //////////////////////////////////////////////////////////////////////////
  // item sequencer and bus master

  always_ff @(posedge mclk) begin
    if (rst) begin
      state_r   <= dma_chan_pkg::ST_IDLE;
      chan_req  <= 1'b0;
      bus_req   <= 1'b0;
      bus_we    <= 1'b0;
      bus_addr  <= 32'h0000_0000;
      bus_wdata <= 32'h0000_0000;
      bus_size  <= 2'h0;
    end else begin
      case (state_r)
        dma_chan_pkg::ST_IDLE: begin
          if (run && trig) begin
            state_r <= dma_chan_pkg::ST_WAIT;
          end else if (run) begin
            state_r  <= dma_chan_pkg::ST_ARB;
            chan_req <= 1'b1;
          end
        end
        dma_chan_pkg::ST_WAIT: begin
          if (!run) begin
            state_r <= dma_chan_pkg::ST_IDLE;
          end else if (req_ok) begin
            state_r  <= dma_chan_pkg::ST_ARB;
            chan_req <= 1'b1;
          end
        end
        dma_chan_pkg::ST_ARB: begin
          if (!run) begin
            state_r  <= dma_chan_pkg::ST_IDLE;
            chan_req <= 1'b0;
          end else if (grant[CHAN]) begin
            state_r  <= dma_chan_pkg::ST_RD;
            chan_req <= 1'b0;
            bus_req  <= 1'b1;
            bus_we   <= 1'b0;
            bus_size <= width_eff(w);
            bus_addr <= calc_addr(src_start, idx_r,
                                  ctrl_r[`CTRL_SRC_INC], w);
          end
        end
        dma_chan_pkg::ST_RD: begin
          if (bus_ack) begin
            state_r   <= dma_chan_pkg::ST_WR;
            bus_we    <= 1'b1;
            bus_wdata <= bus_rdata;
            bus_addr  <= calc_addr(dst_start, idx_r,
                                   ctrl_r[`CTRL_DST_INC], w);
          end
        end
        dma_chan_pkg::ST_WR: begin
          if (bus_ack) begin
            bus_req <= 1'b0;
            bus_we  <= 1'b0;
            if (last_item && restart) begin
              state_r <= dma_chan_pkg::ST_WAIT;
            end else if (last_item || !run) begin
              state_r <= dma_chan_pkg::ST_IDLE;
            end else if (trig) begin
              state_r <= dma_chan_pkg::ST_WAIT;
            end else begin
              state_r  <= dma_chan_pkg::ST_ARB;
              chan_req <= 1'b1;
            end
          end
        end
        default: begin
          state_r  <= dma_chan_pkg::ST_IDLE;
          chan_req <= 1'b0;
          bus_req  <= 1'b0;
          bus_we   <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      idx_r <= `RST_REG16;
    end else if (item_done && last_item) begin
      idx_r <= `RST_REG16;
    end else if (item_done) begin
      idx_r <= idx_r + 16'h0001;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // interrupt: sticky status, cleared by read of the bits returned

  always_comb begin
    events = '0;
    events[`STAT_MATCH] = item_done && match_r == idx_r && irq_en;
    events[`STAT_DONE]  = item_done && last_item;
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      status_r <= `RST_STAT;
    end else if (rd_en && avs_address == `OFS_STATUS) begin
      status_r <= (status_r & ~avs_readdata[`STAT_BITS-1:0]) | events;
    end else begin
      status_r <= status_r | events;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= irq_en && |(status_r & mask_r);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  AST_RUN_SELF_CLEAR: assert property (
    item_done && last_item && !restart && !ctrl_wr |=> !run ##1
    state_r == dma_chan_pkg::ST_IDLE && !bus_req)
    else $error("run bit not cleared after last item");
  AST_WRAP_RESTART: assert property (
    item_done && last_item && restart && !ctrl_wr |=>
    run && idx_r == 16'h0000 && state_r == dma_chan_pkg::ST_WAIT)
    else $error("wrap mode did not restart");
  AST_SRC_ADDR: assert property (
    state_r == dma_chan_pkg::ST_ARB && run && grant[CHAN] |=>
    bus_addr == $past(src_start) +
    ($past(ctrl_r[`CTRL_SRC_INC]) ? {16'h0000, $past(idx_r)} <<
     bus_size : 32'h0))
    else $error("source address wrong");
  AST_DST_ADDR: assert property (
    state_r == dma_chan_pkg::ST_RD && bus_ack |=>
    bus_addr == $past(dst_start) +
    ($past(ctrl_r[`CTRL_DST_INC]) ? {16'h0000, idx_r} << bus_size : 32'h0))
    else $error("destination address wrong");
  AST_PACED: assert property (
    state_r == dma_chan_pkg::ST_WAIT && !req_ok |=> !chan_req && !bus_req)
    else $error("transfer without peripheral request");
  AST_IRQ_GATE: assert property (
    irq |-> $past(irq_en))
    else $error("interrupt while gate clear");
  AST_WIDTH: assert property (
    bus_req |-> bus_size != 2'h3)
    else $error("reserved width on bus");
  AST_IDLE: assert property (
    !run && state_r == dma_chan_pkg::ST_IDLE |=> !chan_req && !bus_req)
    else $error("activity while off");
  AST_INDEX: assert property (
    item_done |=> idx_r == ($past(last_item) ? 16'h0000
                                             : $past(idx_r) + 16'h0001))
    else $error("index step wrong");
  AST_MATCH: assert property (
    item_done && match_r == idx_r && irq_en |=> status_r[`STAT_MATCH])
    else $error("match event lost");
  AST_GRANT: assert property (
    $onehot0(grant) && (!grant[CHAN] || chan_req))
    else $error("grant not one-hot");

  CVR_DONE: cover property (item_done && last_item && !restart);
  CVR_WRAP: cover property (item_done && last_item && restart);
  CVR_IRQ:  cover property ($rose(irq));
  CVR_LOST: cover property (chan_req && !grant[CHAN] ##1 chan_req);

endmodule

//--- hdl/dma_chan_defines.svh
// register offsets, field positions and reset values of one dma channel
`ifndef DMA_CHAN_DEFINES_SVH
`define DMA_CHAN_DEFINES_SVH

// word addresses on the avalon port, equal to the printed offsets
`define OFS_CTRL       32'h5000356c
`define OFS_IDX        32'h5000356e
`define OFS_SRC_LO     32'h50003570
`define OFS_SRC_HI     32'h50003572
`define OFS_DST_LO     32'h50003574
`define OFS_DST_HI     32'h50003576
`define OFS_IRQ_MATCH  32'h50003578
`define OFS_LEN        32'h5000357a
`define OFS_STATUS     32'h50003580
`define OFS_MASK       32'h50003582

// control field positions
`define CTRL_RUN       0
`define CTRL_WIDTH_LO  1
`define CTRL_WIDTH_HI  2
`define CTRL_IRQ_EN    3
`define CTRL_TRIG      4
`define CTRL_DST_INC   5
`define CTRL_SRC_INC   6
`define CTRL_WRAP      7
`define CTRL_PRIO_LO   8
`define CTRL_PRIO_HI   10
`define CTRL_SENSE     13
`define CTRL_WMASK     16'h27ff

// status and mask field positions
`define STAT_MATCH     0
`define STAT_DONE      1
`define STAT_BITS      2

// reset values
`define RST_REG16      16'h0000
`define RST_STAT       2'h0

`endif

//--- hdl/dma_chan_pkg.sv
// types shared by the dma channel modules
package dma_chan_pkg;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_WAIT = 5'h02,
    ST_ARB  = 5'h04,
    ST_RD   = 5'h08,
    ST_WR   = 5'h10
  } chan_state_t;

  typedef enum logic [1:0] {
    W_BYTE = 2'h0,
    W_HALF = 2'h1,
    W_WORD = 2'h2,
    W_RSVD = 2'h3
  } item_width_t;

endpackage

//--- hdl/dma_req_sync.sv
// peripheral request synchroniser with level or rising-edge sense
`timescale 1ns/1ns
module dma_req_sync (
  // clock and reset
  input  wire logic mclk,
  input  wire logic rst,
  // request pin and mode
  input  wire logic dreq,
  input  wire logic edge_sense,
  input  wire logic consume,
  // qualified request
  output logic      req_ok
);

  logic s1_r;
  logic s2_r;
  logic s3_r;
  logic pend_r;

  always_ff @(posedge mclk) begin
    if (rst) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
    end else begin
      s1_r <= dreq;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // a new edge wins over the consume of the old one
  always_ff @(posedge mclk) begin
    if (rst) begin
      pend_r <= 1'b0;
    end else if (s2_r && !s3_r) begin
      pend_r <= 1'b1;
    end else if (consume) begin
      pend_r <= 1'b0;
    end
  end

  assign req_ok = edge_sense ? pend_r : s2_r;

endmodule

//--- hdl/chan_priority_arbiter.sv
// fixed arbiter: higher priority value wins, then lower channel number
`timescale 1ns/1ns
module chan_priority_arbiter #(
  parameter int unsigned NCH = 8
) (
  // requests and priorities of all channels
  input  wire logic [NCH-1:0]   req,
  input  wire logic [3*NCH-1:0] prio,
  // one-hot grant
  output logic      [NCH-1:0]   grant
);

  logic [3:0] best;
  int         win;

  always_comb begin
    best  = 4'h0;
    win   = NCH;
    grant = '0;
    for (int i = 0; i < NCH; i++) begin
      if (req[i] && (win == NCH || {1'b0, prio[3*i +: 3]} > best)) begin
        best = {1'b0, prio[3*i +: 3]};
        win  = i;
      end
    end
    if (win < NCH) begin
      grant[win] = 1'b1;
    end
  end

endmodule

//--- tb/dma_bus_model.sv
// system bus slave answering the channel's item reads and writes
`timescale 1ns/1ns
module dma_bus_model (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rst,
  // item bus from the channel
  input  wire logic        bus_req,
  input  wire logic        bus_we,
  input  wire logic [31:0] bus_addr,
  // answer pacing
  input  wire logic        slow,
  // answer
  output logic             bus_ack,
  output logic      [31:0] bus_rdata
);
  logic [1:0]  wait_r;
  logic [31:0] noise_r;

  ////////////////////////////////////////////////////////////////////////////
  // one-cycle acknowledge, at once or after a few wait cycles
  always_ff @(posedge mclk) begin
    if (rst || !bus_req || bus_ack) begin
      bus_ack <= 1'b0;
      wait_r  <= slow ? 2'h3 : 2'h0;
    end else if (wait_r == 2'h0) begin
      bus_ack <= 1'b1;
    end else begin
      wait_r <= wait_r - 2'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read data only while acking a read, a moving pattern otherwise
  always_ff @(posedge mclk) begin
    if (rst) begin
      noise_r <= 32'h5a5a_0f0f;
    end else begin
      noise_r <= {noise_r[30:0], noise_r[31] ^ noise_r[21]};
    end
  end

  assign bus_rdata = (bus_ack && !bus_we) ? ~bus_addr : noise_r;
endmodule

//--- tb/dma_channel_control_tb.sv
// self-checking bench for one dma channel
`timescale 1ns/1ns
`include "dma_chan_defines.svh"
module dma_channel_control_tb;
  localparam logic [31:0] KEY = 32'h0001_2340;
  logic        mclk, rst, avs_read, avs_write, avs_waitrequest;
  logic [31:0] avs_address, avs_writedata, avs_readdata;
  logic [31:0] bus_addr, bus_wdata, bus_rdata, s, d;
  logic        dreq, secure_boot, bus_req, bus_we, bus_ack;
  logic        chan_req, irq, slow, g;
  logic [1:0]  bus_size, w;
  logic [7:0]  peer_req;
  logic [23:0] peer_prio;
  logic [15:0] ctrl;
  logic [15:0] exp_rd[$];
  logic [33:0] exp_src[$];
  logic [33:0] exp_dst[$];
  logic [33:0] src_e;
  int          errors, n_checks, n, m;
  logic [31:0] ofs [11] = '{`OFS_CTRL, `OFS_IDX, `OFS_SRC_LO, `OFS_SRC_HI,
                           `OFS_DST_LO, `OFS_DST_HI, `OFS_IRQ_MATCH,
                           `OFS_LEN, `OFS_STATUS, `OFS_MASK, 32'h5000_3590};

  dma_channel_control #(.KEY_STORE_BASE(KEY)) u_dma_channel_control (
    .mclk(mclk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_byteenable(4'h3),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .dreq(dreq),
    .secure_boot(secure_boot), .peer_req(peer_req), .peer_prio(peer_prio),
    .bus_req(bus_req), .bus_we(bus_we), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_size(bus_size), .bus_ack(bus_ack),
    .bus_rdata(bus_rdata), .chan_req(chan_req), .irq(irq));

  dma_bus_model u_dma_bus_model (
    .mclk(mclk), .rst(rst), .bus_req(bus_req), .bus_we(bus_we),
    .bus_addr(bus_addr), .slow(slow), .bus_ack(bus_ack),
    .bus_rdata(bus_rdata));

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic check(input string nm, input logic [33:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // one avalon access, held until waitrequest is sampled low
  task automatic acc(input logic wr_en, input logic [31:0] a,
                     input logic [15:0] dat);
    @(posedge mclk);
    avs_address   <= a;
    avs_write     <= wr_en;
    avs_read      <= !wr_en;
    avs_writedata <= {16'h0000, dat};
    do @(posedge mclk); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask

  task automatic wr(input logic [31:0] a, input logic [15:0] dat);
    acc(1'b1, a, dat);
  endtask

  task automatic rd(input logic [31:0] a, input logic [15:0] e);
    exp_rd.push_back(e);
    acc(1'b0, a, 16'h0000);
  endtask

  // expected item addresses, index wrapping every per items
  task automatic items(input logic [31:0] sa, da, input int cnt,
                       input logic [1:0] wd, input logic si, di,
                       input int per);
    logic [31:0] off;
    for (int k = 0; k < cnt; k++) begin
      off = 32'(k % per) << wd;
      exp_src.push_back({wd, sa + (si ? off : 32'h0)});
      exp_dst.push_back({wd, da + (di ? off : 32'h0)});
    end
  endtask

  task automatic drain();
    for (int t = 0; t < 600 && exp_dst.size() != 0; t++) @(posedge mclk);
    repeat (4) @(posedge mclk);
    check("items_left", 34'(exp_dst.size()), 34'h0);
  endtask

  task automatic pulse();
    dreq <= 1'b1;
    repeat (3) @(posedge mclk);
    dreq <= 1'b0;
    repeat (24) @(posedge mclk);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // output watcher: register reads and item bus completions
  always @(posedge mclk) begin
    if (avs_read && !avs_waitrequest)
      check("readdata", avs_readdata, {16'h0, exp_rd.pop_front()});
    if (bus_req && bus_ack && !bus_we) begin
      src_e = exp_src.size() ? exp_src.pop_front() : '1;
      check("src", {bus_size, bus_addr}, src_e);
    end
    if (bus_req && bus_ack && bus_we)
      check("wdata", {2'b00, bus_wdata}, {2'b00, ~src_e[31:0]});
    if (bus_req && bus_ack && bus_we)
      check("dst", {bus_size, bus_addr},
            exp_dst.size() ? exp_dst.pop_front() : '1);
  end

  initial begin
    repeat (30000) @(posedge mclk);
    errors++;
    stop_test();
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(23));
    {rst, avs_read, avs_write, dreq, secure_boot, slow} = 6'b100000;
    avs_address   = 32'h0;
    avs_writedata = 32'h0;
    peer_req      = 8'h00;
    peer_prio     = 24'h0;
    errors        = 0;
    n_checks      = 0;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    foreach (ofs[i]) rd(ofs[i], 16'h0000);
    wr(`OFS_IDX, 16'h1234);
    rd(`OFS_IDX, 16'h0000);
    // normal transfers over widths, increments and pacing
    for (int i = 0; i < 6; i++) begin
      s = $urandom;
      d = $urandom;
      n = $urandom_range(3);
      m = $urandom_range(n + 1);
      g = 1'($urandom_range(1));
      w = 2'(i % 3);
      slow <= (i > 2);
      wr(`OFS_SRC_LO, s[15:0]);
      wr(`OFS_SRC_HI, s[31:16]);
      wr(`OFS_DST_LO, d[15:0]);
      wr(`OFS_DST_HI, d[31:16]);
      rd(`OFS_SRC_HI, s[31:16]);
      rd(`OFS_DST_LO, d[15:0]);
      wr(`OFS_LEN, 16'(n));
      wr(`OFS_IRQ_MATCH, 16'(m));
      wr(`OFS_MASK, 16'h0001);
      ctrl = {9'h000, i[0], i[1] ^ i[0], 1'b0, g, w, 1'b1};
      items(s, d, n + 1, w, i[0], i[1] ^ i[0], n + 1);
      wr(`OFS_CTRL, ctrl);
      drain();
      check("irq", irq, g && (m <= n));
      rd(`OFS_CTRL, ctrl & 16'hfffe);
      rd(`OFS_IDX, 16'h0000);
      rd(`OFS_STATUS, {14'h0, 1'b1, g && (m <= n)});
      rd(`OFS_STATUS, 16'h0000);
    end
    // peripheral paced wrap mode with edge sense
    slow <= 1'b0;
    wr(`OFS_SRC_LO, 16'h0100);
    wr(`OFS_SRC_HI, 16'h0000);
    wr(`OFS_DST_LO, 16'h0200);
    wr(`OFS_DST_HI, 16'h0000);
    wr(`OFS_LEN, 16'h0001);
    items(32'h100, 32'h200, 4, 2'h0, 1'b1, 1'b1, 2);
    wr(`OFS_CTRL, 16'h20f1);
    repeat (10) @(posedge mclk);
    check("idle_bus", bus_req, 1'b0);
    repeat (4) pulse();
    check("items_left", 34'(exp_dst.size()), 34'h0);
    rd(`OFS_CTRL, 16'h20f1);
    rd(`OFS_IDX, 16'h0000);
    wr(`OFS_CTRL, 16'h0000);
    pulse();
    check("off_bus", bus_req, 1'b0);
    // level sensed requests; a peer on a tie or higher priority blocks
    items(32'h100, 32'h200, 2, 2'h0, 1'b1, 1'b1, 2);
    peer_req  <= 8'(1 << $urandom_range(6));
    peer_prio <= 24'($urandom);
    wr(`OFS_CTRL, 16'h0071);
    dreq <= 1'b1;
    repeat (20) @(posedge mclk);
    check("blocked_req", chan_req, 1'b1);
    check("blocked_bus", bus_req, 1'b0);
    peer_req <= 8'h00;
    drain();
    dreq <= 1'b0;
    rd(`OFS_CTRL, 16'h0070);
    // secure boot forces the destination start
    secure_boot <= 1'b1;
    repeat (4) @(posedge mclk);
    wr(`OFS_DST_LO, 16'hffff);
    rd(`OFS_DST_LO, KEY[15:0]);
    rd(`OFS_DST_HI, KEY[31:16]);
    wr(`OFS_LEN, 16'h0000);
    items(32'h100, KEY, 1, 2'h2, 1'b1, 1'b1, 1);
    wr(`OFS_CTRL, 16'h0065);
    drain();
    rd(`OFS_CTRL, 16'h0064);
    repeat (4) @(posedge mclk);
    stop_test();
  end
endmodule
